// File: common/crp_pkg.sv
// Constants shared by the configuration access requester and target.
// Assumes a single 25 MHz clock on both ends and an in-order token link.

package crp_pkg;

	// ==========================================================
	// Tokens
	localparam logic [7:0]  TOK_WR      = 8'hC0;
	localparam logic [7:0]  TOK_RD      = 8'hC1;
	localparam logic [7:0]  TOK_PWR     = 8'h24;
	localparam logic [7:0]  TOK_PRD     = 8'h25;
	localparam logic [7:0]  TOK_END     = 8'h01;
	localparam logic [7:0]  TOK_ACK     = 8'h03;
	localparam logic [7:0]  TOK_NAK     = 8'h04;

	// ==========================================================
	// Destinations and identities; the identity values are arbitrary.
	localparam int          NUM_BANKS   = 10;
	localparam logic [15:0] SFX_TILE    = 16'hC20C;
	localparam logic [15:0] SFX_NODE    = 16'hC30C;
	localparam logic [7:0]  SFX_PERI    = 8'h0D;
	localparam logic [15:0] TILE_ID     = 16'h0001;
	localparam logic [15:0] NODE_ID     = 16'h0002;
	localparam logic [7:0]  PERI_ID     = 8'h01;
	localparam logic [23:0] REQ_CHAN    = 24'h00_0102;

	// ==========================================================
	// Register file sizes and status resource layout.
	localparam logic [16:0] NREG        = 17'h0_0010;
	localparam logic [7:0]  PERI_MAX    = 8'h04;
	localparam logic [7:0]  PS_TAG      = 8'h0C;
	localparam int          PS_SHIFT    = 8;

	// ==========================================================
	// Enumerations
	typedef enum logic [1:0] {
		BANK_NONE = 2'h0,
		BANK_TILE = 2'h1,
		BANK_NODE = 2'h2,
		BANK_PERI = 2'h3
	} crp_bank_e;

	typedef enum logic [1:0] {
		KIND_TILE = 2'h0,
		KIND_NODE = 2'h1,
		KIND_PERI = 2'h2,
		KIND_PS   = 2'h3
	} crp_kind_e;

endpackage

// File: common/crp_cfg_if.sv
// Token link and status port between requester and configuration target.
// Assumes both ends share one clock; the testbench supplies it.
`timescale 1ns/1ps
`default_nettype none

interface crp_cfg_if;
	// Request tokens, requester to target.
	logic        req_valid;
	logic        req_ctrl;
	logic [7:0]  req_data;
	logic        req_ready;
	logic [31:0] dest;
	// Response tokens, target to requester.
	logic        rsp_valid;
	logic        rsp_ctrl;
	logic [7:0]  rsp_data;
	logic        rsp_ready;
	logic [23:0] rsp_dest;
	// Processor status access.
	logic        ps_valid;
	logic        ps_write;
	logic [15:0] ps_resid;
	logic [31:0] ps_wdata;
	logic        ps_done;
	logic        ps_ok;
	logic [31:0] ps_rdata;

	modport dev (
		input  req_valid, req_ctrl, req_data, dest, rsp_ready,
		input  ps_valid, ps_write, ps_resid, ps_wdata,
		output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest,
		output ps_done, ps_ok, ps_rdata
	);

	modport req (
		output req_valid, req_ctrl, req_data, dest, rsp_ready,
		output ps_valid, ps_write, ps_resid, ps_wdata,
		input  req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest,
		input  ps_done, ps_ok, ps_rdata
	);
endinterface // crp_cfg_if

`default_nettype wire

// File: hw/crp_cfg_dev.sv
// Configuration register target: decodes token messages, answers them.
// Assumes the requester holds each token until accepted.
`timescale 1ns/1ps
`default_nettype none

module crp_cfg_dev (
	// Clock and reset
	input  wire logic  REF_CLK,
	input  wire logic  RESET,
	// Link
	crp_cfg_if.dev     LINK,
	// Status
	output logic       BUSY,
	output logic       FAIL,
	output logic [31:0] TILE_CTRL
);

	// ==========================================================
	// State
	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_RID  = 9'h002,
		S_REG  = 9'h004,
		S_SIZE = 9'h008,
		S_DATA = 9'h010,
		S_END  = 9'h020,
		S_ACK  = 9'h040,
		S_RDAT = 9'h080,
		S_FIN  = 9'h100
	} crp_dev_state_e;

	crp_dev_state_e     state_ff, nxt_state;
	crp_pkg::crp_bank_e bank_ff, nxt_bank, dec_bank;
	logic [7:0]  cnt_ff, nxt_cnt;
	logic [23:0] rid_ff, nxt_rid;
	logic [15:0] reg_ff, nxt_reg;
	logic [7:0]  size_ff, nxt_size;
	logic [31:0] dat_ff, nxt_dat;
	logic        bad_ff, nxt_bad;
	logic        wr_ff, nxt_wr;
	logic        in_rdy_ff, nxt_in_rdy;
	logic        o_vld_ff, nxt_o_vld;
	logic        o_ctl_ff, nxt_o_ctl;
	logic [7:0]  o_dat_ff, nxt_o_dat;
	logic        busy_ff, nxt_busy;
	logic        fail_ff, nxt_fail;
	logic [31:0] tile_mem [16];
	logic [31:0] nxt_tile [16];
	logic [31:0] node_mem [16];
	logic [31:0] nxt_node [16];
	logic [7:0]  peri_mem [16];
	logic [7:0]  nxt_peri [16];
	logic [31:0] ps_mem   [16];
	logic [31:0] nxt_ps   [16];
	logic        ps_done_ff, nxt_ps_done;
	logic        ps_ok_ff, nxt_ps_ok;
	logic [31:0] ps_rdata_ff, nxt_ps_rdata;

	logic        acc;
	logic        snd;
	logic        is_end;
	logic        rsp_now;
	logic        ld_byte;
	logic [3:0]  rd_idx;
	logic [7:0]  nbytes;
	logic [16:0] span;

	assign acc    = LINK.req_valid && in_rdy_ff;
	assign snd    = o_vld_ff && LINK.rsp_ready;
	assign is_end = LINK.req_ctrl && (LINK.req_data == crp_pkg::TOK_END);
	assign nbytes = (bank_ff == crp_pkg::BANK_PERI) ? size_ff : 8'h04;
	assign span   = {1'b0, reg_ff} + {9'h000, LINK.req_data};

	// ==========================================================
	// Bank decode from the channel destination.
	always_comb begin
		dec_bank = crp_pkg::BANK_NONE;
		if (LINK.dest == {crp_pkg::TILE_ID, crp_pkg::SFX_TILE}) begin
			dec_bank = crp_pkg::BANK_TILE;
		end else if (LINK.dest == {crp_pkg::NODE_ID, crp_pkg::SFX_NODE}) begin
			dec_bank = crp_pkg::BANK_NODE;
		end else if (LINK.dest == {crp_pkg::NODE_ID, crp_pkg::PERI_ID, crp_pkg::SFX_PERI}) begin
			dec_bank = crp_pkg::BANK_PERI;
		end
	end

	// ==========================================================
	// Message engine.
	always_comb begin
		nxt_state = state_ff;
		nxt_bank  = bank_ff;
		nxt_cnt   = cnt_ff;
		nxt_rid   = rid_ff;
		nxt_reg   = reg_ff;
		nxt_size  = size_ff;
		nxt_dat   = dat_ff;
		nxt_bad   = bad_ff;
		nxt_wr    = wr_ff;
		nxt_o_vld = o_vld_ff;
		nxt_o_ctl = o_ctl_ff;
		nxt_o_dat = o_dat_ff;
		nxt_fail  = 1'b0;
		nxt_tile  = tile_mem;
		nxt_node  = node_mem;
		nxt_peri  = peri_mem;
		rsp_now   = 1'b0;
		ld_byte   = 1'b0;
		rd_idx    = 4'h0;
		case (state_ff)
			S_IDLE: begin
				if (acc) begin
					nxt_cnt  = 8'h00;
					nxt_rid  = 24'h00_0000;
					nxt_reg  = 16'h0000;
					nxt_size = 8'h00;
					nxt_dat  = 32'h0000_0000;
					nxt_bank = dec_bank;
					nxt_bad  = 1'b1;
					nxt_wr   = 1'b0;
					nxt_state = S_END;
					if (LINK.req_ctrl) begin
						case (LINK.req_data)
							crp_pkg::TOK_WR, crp_pkg::TOK_RD: begin
								nxt_wr    = (LINK.req_data == crp_pkg::TOK_WR);
								nxt_bad   = (dec_bank != crp_pkg::BANK_TILE) &&
								            (dec_bank != crp_pkg::BANK_NODE);
								nxt_state = S_RID;
							end
							crp_pkg::TOK_PWR, crp_pkg::TOK_PRD: begin
								nxt_wr    = (LINK.req_data == crp_pkg::TOK_PWR);
								nxt_bad   = (dec_bank != crp_pkg::BANK_PERI);
								nxt_state = S_RID;
							end
							crp_pkg::TOK_END: begin
								rsp_now = 1'b1;
							end
							default: begin
								nxt_state = S_END;
							end
						endcase
					end
				end
			end
			S_RID, S_REG, S_SIZE, S_DATA: begin
				if (acc && LINK.req_ctrl) begin
					nxt_bad = 1'b1;
					if (is_end) begin
						rsp_now = 1'b1;
					end else begin
						nxt_state = S_END;
					end
				end else if (acc) begin
					nxt_cnt = cnt_ff + 8'h01;
					case (state_ff)
						S_RID: begin
							nxt_rid = {rid_ff[15:0], LINK.req_data};
							if (cnt_ff == 8'h02) begin
								nxt_cnt   = 8'h00;
								nxt_state = S_REG;
							end
						end
						S_REG: begin
							nxt_reg = {reg_ff[7:0], LINK.req_data};
							if (bank_ff == crp_pkg::BANK_PERI) begin
								nxt_cnt   = 8'h00;
								nxt_state = S_SIZE;
							end else if (cnt_ff == 8'h01) begin
								nxt_cnt   = 8'h00;
								nxt_state = wr_ff ? S_DATA : S_END;
							end
						end
						S_SIZE: begin
							nxt_size = LINK.req_data;
							nxt_cnt  = 8'h00;
							if (span > crp_pkg::NREG ||
							    (wr_ff && LINK.req_data > crp_pkg::PERI_MAX)) begin
								nxt_bad = 1'b1;
							end
							nxt_state = (wr_ff && LINK.req_data != 8'h00) ? S_DATA : S_END;
						end
						default: begin
							nxt_dat = {dat_ff[23:0], LINK.req_data};
							if (cnt_ff + 8'h01 == nbytes) begin
								nxt_state = S_END;
							end
						end
					endcase
				end
			end
			S_END: begin
				if (acc) begin
					if (is_end) begin
						rsp_now = 1'b1;
					end else begin
						nxt_bad = 1'b1;
					end
				end
			end
			S_ACK: begin
				if (snd) begin
					if (!bad_ff && !wr_ff && nbytes != 8'h00) begin
						nxt_state = S_RDAT;
						nxt_cnt   = 8'h00;
						ld_byte   = 1'b1;
					end else begin
						nxt_state = S_FIN;
						nxt_o_dat = crp_pkg::TOK_END;
					end
				end
			end
			S_RDAT: begin
				if (snd) begin
					nxt_cnt = cnt_ff + 8'h01;
					nxt_dat = {dat_ff[23:0], 8'h00};
					if (cnt_ff + 8'h01 == nbytes) begin
						nxt_state = S_FIN;
						nxt_o_ctl = 1'b1;
						nxt_o_dat = crp_pkg::TOK_END;
					end else begin
						ld_byte = 1'b1;
					end
				end
			end
			S_FIN: begin
				if (snd) begin
					nxt_o_vld = 1'b0;
					nxt_state = S_IDLE;
				end
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
		if (rsp_now) begin
			if (nxt_bank != crp_pkg::BANK_PERI && {1'b0, nxt_reg} >= crp_pkg::NREG) begin
				nxt_bad = 1'b1;
			end
			if (!nxt_bad && nxt_wr) begin
				case (nxt_bank)
					crp_pkg::BANK_TILE: nxt_tile[nxt_reg[3:0]] = nxt_dat;
					crp_pkg::BANK_NODE: nxt_node[nxt_reg[3:0]] = nxt_dat;
					default: begin
						for (int i = 0; i < 4; i++) begin
							if (i < int'(nxt_size)) begin
								nxt_peri[nxt_reg[3:0] + 4'(i)] =
									nxt_dat[8 * (int'(nxt_size) - 1 - i) +: 8];
							end
						end
					end
				endcase
			end else if (!nxt_bad) begin
				nxt_dat = (nxt_bank == crp_pkg::BANK_NODE) ? node_mem[nxt_reg[3:0]]
				                                          : tile_mem[nxt_reg[3:0]];
			end
			nxt_state = S_ACK;
			nxt_o_vld = 1'b1;
			nxt_o_ctl = 1'b1;
			nxt_o_dat = nxt_bad ? crp_pkg::TOK_NAK : crp_pkg::TOK_ACK;
			nxt_fail  = nxt_bad;
		end
		if (ld_byte) begin
			rd_idx    = reg_ff[3:0] + nxt_cnt[3:0];
			nxt_o_ctl = 1'b0;
			nxt_o_dat = (bank_ff == crp_pkg::BANK_PERI) ? peri_mem[rd_idx] : nxt_dat[31:24];
		end
		nxt_in_rdy = (nxt_state == S_IDLE) || (nxt_state == S_RID) ||
		             (nxt_state == S_REG) || (nxt_state == S_SIZE) ||
		             (nxt_state == S_DATA) || (nxt_state == S_END);
		nxt_busy   = (nxt_state != S_IDLE);
	end

	// ==========================================================
	// Processor status access, one word per request.
	always_comb begin
		nxt_ps       = ps_mem;
		nxt_ps_done  = LINK.ps_valid;
		nxt_ps_ok    = LINK.ps_valid && (LINK.ps_resid[7:0] == crp_pkg::PS_TAG) &&
		               ({9'h000, LINK.ps_resid[15:8]} < crp_pkg::NREG);
		nxt_ps_rdata = 32'h0000_0000;
		if (nxt_ps_ok && LINK.ps_write) begin
			nxt_ps[LINK.ps_resid[11:8]] = LINK.ps_wdata;
		end else if (nxt_ps_ok) begin
			nxt_ps_rdata = ps_mem[LINK.ps_resid[11:8]];
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			state_ff    <= S_IDLE;
			bank_ff     <= crp_pkg::BANK_NONE;
			cnt_ff      <= 8'h00;
			rid_ff      <= 24'h00_0000;
			reg_ff      <= 16'h0000;
			size_ff     <= 8'h00;
			dat_ff      <= 32'h0000_0000;
			bad_ff      <= 1'b0;
			wr_ff       <= 1'b0;
			in_rdy_ff   <= 1'b0;
			o_vld_ff    <= 1'b0;
			o_ctl_ff    <= 1'b0;
			o_dat_ff    <= 8'h00;
			busy_ff     <= 1'b0;
			fail_ff     <= 1'b0;
			ps_done_ff  <= 1'b0;
			ps_ok_ff    <= 1'b0;
			ps_rdata_ff <= 32'h0000_0000;
			for (int i = 0; i < 16; i++) begin
				tile_mem[i] <= 32'h0000_0000;
				node_mem[i] <= 32'h0000_0000;
				peri_mem[i] <= 8'h00;
				ps_mem[i]   <= 32'h0000_0000;
			end
		end else begin
			state_ff    <= nxt_state;
			bank_ff     <= nxt_bank;
			cnt_ff      <= nxt_cnt;
			rid_ff      <= nxt_rid;
			reg_ff      <= nxt_reg;
			size_ff     <= nxt_size;
			dat_ff      <= nxt_dat;
			bad_ff      <= nxt_bad;
			wr_ff       <= nxt_wr;
			in_rdy_ff   <= nxt_in_rdy;
			o_vld_ff    <= nxt_o_vld;
			o_ctl_ff    <= nxt_o_ctl;
			o_dat_ff    <= nxt_o_dat;
			busy_ff     <= nxt_busy;
			fail_ff     <= nxt_fail;
			ps_done_ff  <= nxt_ps_done;
			ps_ok_ff    <= nxt_ps_ok;
			ps_rdata_ff <= nxt_ps_rdata;
			tile_mem    <= nxt_tile;
			node_mem    <= nxt_node;
			peri_mem    <= nxt_peri;
			ps_mem      <= nxt_ps;
		end
	end

	assign LINK.req_ready = in_rdy_ff;
	assign LINK.rsp_valid = o_vld_ff;
	assign LINK.rsp_ctrl  = o_ctl_ff;
	assign LINK.rsp_data  = o_dat_ff;
	assign LINK.rsp_dest  = rid_ff;
	assign LINK.ps_done   = ps_done_ff;
	assign LINK.ps_ok     = ps_ok_ff;
	assign LINK.ps_rdata  = ps_rdata_ff;
	assign BUSY           = busy_ff;
	assign FAIL           = fail_ff;
	assign TILE_CTRL      = tile_mem[0];

endmodule // crp_cfg_dev

`default_nettype wire

// File: hw/crp_cfg_req.sv
// Configuration requester: turns user commands into token messages or status port accesses.
// Assumes the target answers each message before the next is sent.
`timescale 1ns/1ps
`default_nettype none

module crp_cfg_req (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	// Link
	crp_cfg_if.req           LINK,
	// Command
	input  wire logic        CMD_VALID,
	input  wire logic [1:0]  CMD_KIND,
	input  wire logic        CMD_WRITE,
	input  wire logic [15:0] CMD_REG,
	input  wire logic [2:0]  CMD_SIZE,
	input  wire logic [31:0] CMD_WDATA,
	output logic             CMD_READY,
	// Result
	output logic             RES_VALID,
	output logic             RES_OK,
	output logic [31:0]      RES_DATA
);

	// ==========================================================
	// State
	typedef enum logic [3:0] {
		Q_IDLE = 4'h1,
		Q_SEND = 4'h2,
		Q_WAIT = 4'h4,
		Q_PS   = 4'h8
	} crp_req_state_e;

	crp_req_state_e state_ff, nxt_state;
	logic [95:0] buf_ff, nxt_buf;
	logic [11:0] ctl_ff, nxt_ctl;
	logic [3:0]  left_ff, nxt_left;
	logic [31:0] dest_ff, nxt_dest;
	logic        o_vld_ff, nxt_o_vld;
	logic        rsp_rdy_ff, nxt_rsp_rdy;
	logic        cmd_rdy_ff, nxt_cmd_rdy;
	logic        res_vld_ff, nxt_res_vld;
	logic        ok_ff, nxt_ok;
	logic [31:0] acc_ff, nxt_acc;
	logic        ps_vld_ff, nxt_ps_vld;
	logic        ps_wr_ff, nxt_ps_wr;
	logic [15:0] ps_id_ff, nxt_ps_id;
	logic [31:0] ps_wd_ff, nxt_ps_wd;
	logic [2:0]  sz;
	logic [3:0]  pos;
	logic [31:0] wd;

	always_comb begin
		nxt_state   = state_ff;
		nxt_buf     = buf_ff;
		nxt_ctl     = ctl_ff;
		nxt_left    = left_ff;
		nxt_dest    = dest_ff;
		nxt_o_vld   = o_vld_ff;
		nxt_rsp_rdy = rsp_rdy_ff;
		nxt_cmd_rdy = cmd_rdy_ff;
		nxt_res_vld = 1'b0;
		nxt_ok      = ok_ff;
		nxt_acc     = acc_ff;
		nxt_ps_vld  = 1'b0;
		nxt_ps_wr   = ps_wr_ff;
		nxt_ps_id   = ps_id_ff;
		nxt_ps_wd   = ps_wd_ff;
		sz          = (CMD_SIZE > 3'h4) ? 3'h4 : CMD_SIZE;
		pos         = 4'h6 + {1'b0, sz};
		wd          = CMD_WDATA << (6'(4 - int'(sz)) * 6'h08);
		case (state_ff)
			Q_IDLE: begin
				if (CMD_VALID && cmd_rdy_ff) begin
					nxt_cmd_rdy = 1'b0;
					nxt_acc     = 32'h0000_0000;
					nxt_ctl     = 12'h802;
					nxt_left    = 4'h7;
					nxt_o_vld   = 1'b1;
					nxt_state   = Q_SEND;
					case (CMD_KIND)
						crp_pkg::KIND_TILE, crp_pkg::KIND_NODE: begin
							nxt_dest = (CMD_KIND == crp_pkg::KIND_TILE) ?
							           {crp_pkg::TILE_ID, crp_pkg::SFX_TILE} :
							           {crp_pkg::NODE_ID, crp_pkg::SFX_NODE};
							if (CMD_WRITE) begin
								nxt_buf  = {crp_pkg::TOK_WR, crp_pkg::REQ_CHAN, CMD_REG,
								            CMD_WDATA, crp_pkg::TOK_END, 8'h00};
								nxt_ctl  = 12'h802;
								nxt_left = 4'hB;
							end else begin
								nxt_buf  = {crp_pkg::TOK_RD, crp_pkg::REQ_CHAN, CMD_REG,
								            crp_pkg::TOK_END, 40'h00_0000_0000};
								nxt_ctl  = 12'h820;
							end
						end
						crp_pkg::KIND_PERI: begin
							nxt_dest = {crp_pkg::NODE_ID, crp_pkg::PERI_ID, crp_pkg::SFX_PERI};
							if (CMD_WRITE) begin
								nxt_buf  = {crp_pkg::TOK_PWR, crp_pkg::REQ_CHAN, CMD_REG[7:0],
								            5'h00, sz, wd, 16'h0000} |
								           ({crp_pkg::TOK_END, 88'h0} >> (7'(pos) * 7'h08));
								nxt_ctl  = 12'h800 | (12'h800 >> pos);
								nxt_left = pos + 4'h1;
							end else begin
								nxt_buf  = {crp_pkg::TOK_PRD, crp_pkg::REQ_CHAN, CMD_REG[7:0],
								            5'h00, sz, crp_pkg::TOK_END, 40'h00_0000_0000};
								nxt_ctl  = 12'h820;
							end
						end
						default: begin
							nxt_o_vld  = 1'b0;
							nxt_state  = Q_PS;
							nxt_ps_vld = 1'b1;
							nxt_ps_wr  = CMD_WRITE;
							nxt_ps_wd  = CMD_WDATA;
							nxt_ps_id  = ({8'h00, CMD_REG[7:0]} << crp_pkg::PS_SHIFT) |
							             {8'h00, crp_pkg::PS_TAG};
						end
					endcase
				end
			end
			Q_SEND: begin
				if (o_vld_ff && LINK.req_ready) begin
					nxt_buf  = {buf_ff[87:0], 8'h00};
					nxt_ctl  = {ctl_ff[10:0], 1'b0};
					nxt_left = left_ff - 4'h1;
					if (left_ff == 4'h1) begin
						nxt_o_vld   = 1'b0;
						nxt_rsp_rdy = 1'b1;
						nxt_state   = Q_WAIT;
					end
				end
			end
			Q_WAIT: begin
				if (LINK.rsp_valid && rsp_rdy_ff) begin
					if (!LINK.rsp_ctrl) begin
						nxt_acc = {acc_ff[23:0], LINK.rsp_data};
					end else if (LINK.rsp_data == crp_pkg::TOK_END) begin
						nxt_rsp_rdy = 1'b0;
						nxt_res_vld = 1'b1;
						nxt_cmd_rdy = 1'b1;
						nxt_state   = Q_IDLE;
					end else begin
						nxt_ok = (LINK.rsp_data == crp_pkg::TOK_ACK);
					end
				end
			end
			Q_PS: begin
				if (LINK.ps_done) begin
					nxt_ok      = LINK.ps_ok;
					nxt_acc     = LINK.ps_rdata;
					nxt_res_vld = 1'b1;
					nxt_cmd_rdy = 1'b1;
					nxt_state   = Q_IDLE;
				end
			end
			default: begin
				nxt_state = Q_IDLE;
			end
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			state_ff   <= Q_IDLE;
			buf_ff     <= 96'h0;
			ctl_ff     <= 12'h000;
			left_ff    <= 4'h0;
			dest_ff    <= 32'h0000_0000;
			o_vld_ff   <= 1'b0;
			rsp_rdy_ff <= 1'b0;
			cmd_rdy_ff <= 1'b1;
			res_vld_ff <= 1'b0;
			ok_ff      <= 1'b0;
			acc_ff     <= 32'h0000_0000;
			ps_vld_ff  <= 1'b0;
			ps_wr_ff   <= 1'b0;
			ps_id_ff   <= 16'h0000;
			ps_wd_ff   <= 32'h0000_0000;
		end else begin
			state_ff   <= nxt_state;
			buf_ff     <= nxt_buf;
			ctl_ff     <= nxt_ctl;
			left_ff    <= nxt_left;
			dest_ff    <= nxt_dest;
			o_vld_ff   <= nxt_o_vld;
			rsp_rdy_ff <= nxt_rsp_rdy;
			cmd_rdy_ff <= nxt_cmd_rdy;
			res_vld_ff <= nxt_res_vld;
			ok_ff      <= nxt_ok;
			acc_ff     <= nxt_acc;
			ps_vld_ff  <= nxt_ps_vld;
			ps_wr_ff   <= nxt_ps_wr;
			ps_id_ff   <= nxt_ps_id;
			ps_wd_ff   <= nxt_ps_wd;
		end
	end

	assign LINK.req_valid = o_vld_ff;
	assign LINK.req_ctrl  = ctl_ff[11];
	assign LINK.req_data  = buf_ff[95:88];
	assign LINK.dest      = dest_ff;
	assign LINK.rsp_ready = rsp_rdy_ff;
	assign LINK.ps_valid  = ps_vld_ff;
	assign LINK.ps_write  = ps_wr_ff;
	assign LINK.ps_resid  = ps_id_ff;
	assign LINK.ps_wdata  = ps_wd_ff;
	assign CMD_READY      = cmd_rdy_ff;
	assign RES_VALID      = res_vld_ff;
	assign RES_OK         = ok_ff;
	assign RES_DATA       = acc_ff;

endmodule // crp_cfg_req

`default_nettype wire

// File: tb/crp_cfg_chk.sv
// Checker: assertions on the link and status port.
// Assumes one clock and an async active-high reset.
`timescale 1ns/1ps
`default_nettype none

module crp_cfg_chk (
	// Clock and reset
	input wire logic        REF_CLK,
	input wire logic        RESET,
	// Link
	input wire logic        req_valid,
	input wire logic        req_ctrl,
	input wire logic [7:0]  req_data,
	input wire logic        req_ready,
	input wire logic        rsp_valid,
	input wire logic        rsp_ctrl,
	input wire logic [7:0]  rsp_data,
	input wire logic        rsp_ready,
	// Status
	input wire logic        ps_valid,
	input wire logic [15:0] ps_resid,
	input wire logic        ps_done,
	input wire logic        ps_ok,
	input wire logic [31:0] ps_rdata
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	// ==========================================================
	// Steps
	sequence end_in;
		req_valid && req_ready && req_ctrl && req_data == crp_pkg::TOK_END;
	endsequence
	sequence end_out;
		rsp_valid && rsp_ready && rsp_ctrl && rsp_data == crp_pkg::TOK_END;
	endsequence

	// ==========================================================
	// Assertions
	a_rsp_opens: assert property (end_in |=> rsp_valid && rsp_ctrl &&
		(rsp_data == crp_pkg::TOK_ACK || rsp_data == crp_pkg::TOK_NAK))
		else $error("reply does not open with ack or nak");
	a_nak_then_end: assert property (rsp_valid && rsp_ready && rsp_ctrl &&
		rsp_data == crp_pkg::TOK_NAK |=> rsp_valid && rsp_ctrl &&
		rsp_data == crp_pkg::TOK_END) else $error("nak not closed by end");
	a_rsp_held: assert property (rsp_valid && !rsp_ready |=> rsp_valid &&
		$stable(rsp_data) && $stable(rsp_ctrl)) else $error("reply token dropped");
	a_busy_refuse: assert property (rsp_valid |-> !req_ready)
		else $error("request taken during reply");
	a_rsp_bounded: assert property (end_in |-> ##[1:12] end_out)
		else $error("reply not closed in time");
	a_ps_answer: assert property (ps_valid |=> ps_done)
		else $error("status access unanswered");
	a_ps_fail_zero: assert property (ps_done && !ps_ok |-> ps_rdata == 32'h0000_0000)
		else $error("failed status read returned data");
	a_ps_tag_form: assert property (ps_valid |-> ps_resid[7:0] == crp_pkg::PS_TAG)
		else $error("status resource id malformed");
endmodule // crp_cfg_chk

`default_nettype wire

// File: tb/config_register_access_protocol_tb.sv
// Bench: requester and target joined by one link.
// Assumes package, interface and both ends compile first.
`timescale 1ns/1ps
`default_nettype none

module config_register_access_protocol_tb;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        c_vld = 1'b0;
	logic [1:0]  c_knd = 2'h0;
	logic        c_wr = 1'b0;
	logic [15:0] c_reg = 16'h0000;
	logic [2:0]  c_sz = 3'h0;
	logic [31:0] c_wd = 32'h0000_0000;
	logic        c_rdy, r_vld, r_ok, busy, fail;
	logic [31:0] r_dat, t_ctl;
	logic [31:0] rnd;
	logic [7:0]  tok1;
	logic [31:0] bank_m [4][16] = '{default: 32'h0000_0000};
	int          bad_count = 0;
	int          cmp_count = 0;
	int          req_n = 0;
	int          rsp_n = 0;
	int          fail_n = 0;

	crp_cfg_if link ();
	crp_cfg_dev u_crp_cfg_dev (.REF_CLK(ref_clk), .RESET(reset), .LINK(link),
		.BUSY(busy), .FAIL(fail), .TILE_CTRL(t_ctl));
	crp_cfg_req u_crp_cfg_req (.REF_CLK(ref_clk), .RESET(reset), .LINK(link),
		.CMD_VALID(c_vld), .CMD_KIND(c_knd), .CMD_WRITE(c_wr), .CMD_REG(c_reg),
		.CMD_SIZE(c_sz), .CMD_WDATA(c_wd), .CMD_READY(c_rdy),
		.RES_VALID(r_vld), .RES_OK(r_ok), .RES_DATA(r_dat));
	crp_cfg_chk u_chk (.REF_CLK(ref_clk), .RESET(reset),
		.req_valid(link.req_valid), .req_ctrl(link.req_ctrl), .req_data(link.req_data),
		.req_ready(link.req_ready), .rsp_valid(link.rsp_valid), .rsp_ctrl(link.rsp_ctrl),
		.rsp_data(link.rsp_data), .rsp_ready(link.rsp_ready), .ps_valid(link.ps_valid),
		.ps_resid(link.ps_resid), .ps_done(link.ps_done), .ps_ok(link.ps_ok),
		.ps_rdata(link.ps_rdata));

	always #20 ref_clk = ~ref_clk;

	// ==========================================================
	// Link monitor
	always @(posedge ref_clk) begin
		if (link.req_valid && link.req_ready) begin
			req_n <= req_n + 1;
			if (link.req_ctrl && link.req_data != crp_pkg::TOK_END) tok1 <= link.req_data;
		end
		if (link.rsp_valid && link.rsp_ready) rsp_n <= rsp_n + 1;
		if (fail === 1'b1) fail_n <= fail_n + 1;
	end

	// ==========================================================
	// Expectations
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic int n_req(input logic [1:0] k, input logic w, input int s);
		if (k == 2'h3) return 0;
		if (k == 2'h2) return w ? 7 + s : 7;
		return w ? 11 : 7;
	endfunction
	function automatic int n_rsp(input logic [1:0] k, input logic w, input logic ok, input int s);
		if (k == 2'h3) return 0;
		if (!ok || w) return 2;
		return (k == 2'h2) ? 2 + s : 6;
	endfunction
	function automatic logic [7:0] first_tok(input logic [1:0] k, input logic w);
		if (k == 2'h2) return w ? crp_pkg::TOK_PWR : crp_pkg::TOK_PRD;
		return w ? crp_pkg::TOK_WR : crp_pkg::TOK_RD;
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		cmp_count++;
		if (seen !== ex) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, ex, seen);
		end
	endtask

	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic run(input logic [1:0] k, input logic w, input logic [15:0] r,
		input logic [2:0] sz, input logic [31:0] d);
		int n0, m0, f0, i, s, j;
		logic ok;
		logic [31:0] ex, msk;
		n0 = req_n;
		m0 = rsp_n;
		f0 = fail_n;
		i = 0;
		s = (sz > 3'h4) ? 4 : int'(sz);
		ok = (r < 16) && (k != 2'h2 || r + s <= 16);
		ex = bank_m[k][r[3:0]];
		if (k == 2'h2) ex = 32'h0000_0000;
		for (j = 0; k == 2'h2 && j < s; j++) ex = {ex[23:0], bank_m[2][r[3:0] + j][7:0]};
		msk = (k == 2'h2 && s < 4) ? (32'h0000_0001 << (8 * s)) - 32'h0000_0001 : '1;
		c_vld <= 1'b1;
		c_knd <= k;
		c_wr <= w;
		c_reg <= r;
		c_sz <= sz;
		c_wd <= d;
		do begin
			@(posedge ref_clk);
			i++;
		end while (c_rdy !== 1'b1 && i < 300);
		c_vld <= 1'b0;
		do begin
			@(posedge ref_clk);
			i++;
		end while (r_vld !== 1'b1 && i < 300);
		if (i >= 300) begin
			bad_count++;
			$display("[ERR] result timeout");
			conclude();
		end else begin
			check("res_ok", 32'(r_ok), 32'(ok));
			if (ok && !w) check("res_data", r_dat & msk, ex & msk);
			check("req_count", 32'(req_n - n0), 32'(n_req(k, w, s)));
			check("rsp_count", 32'(rsp_n - m0), 32'(n_rsp(k, w, ok, s)));
			check("fail_count", 32'(fail_n - f0), 32'(k != 2'h3 && !ok));
			check("busy", 32'(busy), 32'h0000_0000);
			if (k != 2'h3) check("rsp_dest", 32'(link.rsp_dest), 32'(crp_pkg::REQ_CHAN));
			if (k != 2'h3) check("first_tok", 32'(tok1), 32'(first_tok(k, w)));
			for (j = 0; ok && w && k == 2'h2 && j < s; j++)
				bank_m[2][r[3:0] + j] = {24'h00_0000, d[8 * (s - 1 - j) +: 8]};
			if (ok && w && k != 2'h2) bank_m[k][r[3:0]] = d;
			$display("test done kind %0d reg %0d", k, r);
		end
	endtask

	initial begin
		rnd = 32'h0000_07a8;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		run(2'h0, 1'b1, 16'h0000, 3'h0, 32'hFFFF_FFFF);
		run(2'h0, 1'b0, 16'h0000, 3'h0, 32'h0000_0000);
		run(2'h0, 1'b1, 16'h0100, 3'h0, 32'h0000_0000);
		run(2'h1, 1'b1, 16'h000F, 3'h0, 32'hA5A5_0F0F);
		run(2'h1, 1'b0, 16'h000F, 3'h0, 32'h0000_0000);
		run(2'h2, 1'b1, 16'h000E, 3'h2, 32'h0000_BEEF);
		run(2'h2, 1'b1, 16'h000E, 3'h3, 32'h0012_3456);
		run(2'h2, 1'b0, 16'h000E, 3'h2, 32'h0000_0000);
		run(2'h2, 1'b0, 16'h0000, 3'h0, 32'h0000_0000);
		run(2'h2, 1'b1, 16'h0004, 3'h7, 32'hCAFE_F00D);
		run(2'h2, 1'b0, 16'h0004, 3'h4, 32'h0000_0000);
		run(2'h3, 1'b1, 16'h000F, 3'h0, 32'h1357_9BDF);
		run(2'h3, 1'b0, 16'h000F, 3'h0, 32'h0000_0000);
		run(2'h3, 1'b1, 16'h0010, 3'h0, 32'h0000_0001);
		repeat (80) begin
			rnd = lfsr(rnd);
			run(rnd[1:0], rnd[2], (rnd[1:0] == 2'h2) ? {12'h000, rnd[7:4]} : {11'h000, rnd[8:4]},
				rnd[11:9], lfsr(rnd));
		end
		check("tile_ctrl", t_ctl, bank_m[0][0]);
		conclude();
	end
endmodule // config_register_access_protocol_tb

`default_nettype wire
